// [rtl/spm_pkg.sv]
package spm_pkg;

  localparam int          ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  MODE_OFS   = 8'h04;
  localparam logic [7:0]  CLKSEL_OFS = 8'h08;
  localparam logic [7:0]  STAT_OFS   = 8'h0C;

  // power_save_control_reg fields
  localparam int          CTRL_PIN_NMI_MASK_BIT = 0;
  localparam int          CTRL_WDT_NMI_MASK_BIT = 1;
  localparam int          CTRL_MASKABLE_MASK_BIT = 2;
  localparam int          CTRL_STANDBY_REQ_BIT = 3;
  // power_save_mode_reg field
  localparam int          MODE_STANDBY_SEL_BIT = 0;
  // Clock select field
  localparam int          CLKSEL_CPU_SRC_BIT = 0;
  // Status fields
  localparam int          STAT_STATE_LSB = 0;
  localparam int          STAT_HOLD_BIT  = 2;
  localparam int          STAT_SRC_LSB   = 3;

  // Reset values
  localparam logic        WAKE_MASK_RST   = 1'b0;
  localparam logic        STANDBY_SEL_RST = 1'b1;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_NORMAL  = 2'b00,
    ST_SUB     = 2'b01,
    ST_SUBIDLE = 2'b10
  } spm_state_t;

  typedef enum logic [2:0] {
    SRC_NONE     = 3'b000,
    SRC_PIN_NMI  = 3'b001,
    SRC_WDT_NMI  = 3'b010,
    SRC_MASKABLE = 3'b011,
    SRC_RESET    = 3'b100
  } spm_src_t;

endpackage

// [rtl/spm_sub_idle_ctrl.sv]
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// Function
// - Enter sub-idle: select 0, request 1, subclock mode
// - Sub-idle keeps oscillator, gates CPU and peripheral clocks
// - Sub-idle halts execution, retains internal RAM
// - Subclock or externally clocked peripherals keep running
// - Wake on pin NMI or watchdog interrupt
// - Wake on unmasked external or internal request
// - Leave on reset pin or watchdog reset
// - Interrupt wake returns to subclock mode
// - Reset wake goes to normal mode
// - Wake regardless of request priority
// - Lower priority in service: wake, no acknowledge
// - Unacknowledged waking request stays pending
// - NMI, or higher priority with interrupts enabled: wake and acknowledge
// - NMI wake always branches to handler
// - Maskable wake, enabled: branch or next instruction
// - Maskable wake, disabled: execute next instruction
// - Masked wake source is ignored
// - Subclock trigger only from timer match, external count
// - Clearing clock source or reset restores normal
module spm_sub_idle_ctrl (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [spm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic [1:0]                     s_axi_bresp,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire logic [spm_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  input  wire logic                      nmi_pin,
  input  wire logic                      second_watchdog_interrupt,
  input  wire logic [7:0]                external_interrupt_pins,
  input  wire logic [7:0]                periph_wake_irq,
  input  wire logic [2:0]                req_prio,
  input  wire logic                      in_service,
  input  wire logic [2:0]                service_prio,
  input  wire logic                      int_enable,
  input  wire logic                      reset_pin_req,
  input  wire logic                      second_watchdog_reset,
  input  wire logic                      byte_timer_match_interrupt,
  input  wire logic                      rto_sel_timer_match,
  input  wire logic                      byte_timer_external_input,
  input  wire logic                      rto_other_trigger,
  output logic                           osc_en,
  output logic                           cpu_clk_en,
  output logic                           periph_clk_en,
  output logic                           sub_periph_clk_en,
  output logic                           cpu_halt,
  output logic                           ram_retain,
  output logic [1:0]                     mode_state,
  output logic                           wake_ack,
  output logic                           branch_handler,
  output logic                           resume_next,
  output logic                           req_hold,
  output logic                           sys_reset_req,
  output logic                           rto_trigger
);

  spm_pkg::spm_state_t state_r;
  spm_pkg::spm_state_t state_nxt;
  spm_pkg::spm_src_t   src_r;

  logic                       pin_nmi_wake_mask_r;
  logic                       watchdog_nmi_wake_mask_r;
  logic                       maskable_wake_mask_r;
  logic                       standby_select_bit_r;
  logic                       req_hold_r;

  logic                       aw_got_r;
  logic                       w_got_r;
  logic [spm_pkg::ADDR_W-1:0] awaddr_r;
  logic [31:0]                wdata_r;
  logic [3:0]                 wstrb_r;

  logic on_sub;
  logic rst_evt;
  logic pin_nmi_wake;
  logic wdt_nmi_wake;
  logic nmi_wake;
  logic mask_wake;
  logic low_prio;
  logic any_wake;
  logic wake_evt;
  logic wr_go;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_clk;
  logic wr_stat;
  logic wr_hit;
  logic enter_ok;
  logic [31:0] rd_val;
  logic        rd_hit;

  assign on_sub       = (state_r != spm_pkg::ST_NORMAL);
  // Watchdog reset only counts while the CPU runs on the subclock
  assign rst_evt      = reset_pin_req | (second_watchdog_reset & on_sub);
  assign pin_nmi_wake = nmi_pin & ~pin_nmi_wake_mask_r;
  assign wdt_nmi_wake = second_watchdog_interrupt & on_sub & ~watchdog_nmi_wake_mask_r;
  assign nmi_wake     = pin_nmi_wake | wdt_nmi_wake;
  // Priority plays no part in waking, only in acknowledging
  assign mask_wake    = ((|external_interrupt_pins) | (|periph_wake_irq))
                        & ~maskable_wake_mask_r;
  assign low_prio     = in_service & (req_prio >= service_prio);
  assign any_wake     = nmi_wake | mask_wake;
  assign wake_evt     = (state_r == spm_pkg::ST_SUBIDLE) & any_wake & ~rst_evt;

  assign wr_go   = aw_got_r & w_got_r & ~s_axi_bvalid;
  assign wr_ctrl = wr_go & wstrb_r[0] & (awaddr_r == spm_pkg::CTRL_OFS);
  assign wr_mode = wr_go & wstrb_r[0] & (awaddr_r == spm_pkg::MODE_OFS);
  assign wr_clk  = wr_go & wstrb_r[0] & (awaddr_r == spm_pkg::CLKSEL_OFS);
  assign wr_stat = wr_go & wstrb_r[0] & (awaddr_r == spm_pkg::STAT_OFS);
  assign wr_hit  = (awaddr_r == spm_pkg::CTRL_OFS) | (awaddr_r == spm_pkg::MODE_OFS)
                 | (awaddr_r == spm_pkg::CLKSEL_OFS) | (awaddr_r == spm_pkg::STAT_OFS);

  // Standby request only honoured from subclock mode; the bit is not stored
  assign enter_ok = (state_r == spm_pkg::ST_SUB) & wr_ctrl
                  & wdata_r[spm_pkg::CTRL_STANDBY_REQ_BIT]
                  & ~standby_select_bit_r;

  always_comb begin
    state_nxt = state_r;
    if (rst_evt) begin
      state_nxt = spm_pkg::ST_NORMAL;
    end else begin
      case (state_r)
        spm_pkg::ST_NORMAL: begin
          if (wr_clk && wdata_r[spm_pkg::CLKSEL_CPU_SRC_BIT]) begin
            state_nxt = spm_pkg::ST_SUB;
          end
        end
        spm_pkg::ST_SUB: begin
          if (wr_clk && !wdata_r[spm_pkg::CLKSEL_CPU_SRC_BIT]) begin
            state_nxt = spm_pkg::ST_NORMAL;
          end else if (enter_ok) begin
            state_nxt = spm_pkg::ST_SUBIDLE;
          end
        end
        spm_pkg::ST_SUBIDLE: begin
          if (any_wake) begin
            state_nxt = spm_pkg::ST_SUB;
          end
        end
        default: state_nxt = spm_pkg::ST_NORMAL;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= spm_pkg::ST_NORMAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Clock gating outputs are registered from the next state so they line up with state_r
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_en            <= 1'b1;
      cpu_clk_en        <= 1'b1;
      periph_clk_en     <= 1'b1;
      sub_periph_clk_en <= 1'b1;
      cpu_halt          <= 1'b0;
      ram_retain        <= 1'b0;
      mode_state        <= spm_pkg::ST_NORMAL;
    end else begin
      osc_en            <= 1'b1;
      cpu_clk_en        <= (state_nxt != spm_pkg::ST_SUBIDLE);
      periph_clk_en     <= (state_nxt != spm_pkg::ST_SUBIDLE);
      sub_periph_clk_en <= 1'b1;
      cpu_halt          <= (state_nxt == spm_pkg::ST_SUBIDLE);
      ram_retain        <= (state_nxt == spm_pkg::ST_SUBIDLE);
      mode_state        <= state_nxt;
    end
  end

  // Wake outcome towards CPU and interrupt controller
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_ack       <= 1'b0;
      branch_handler <= 1'b0;
      resume_next    <= 1'b0;
      sys_reset_req  <= 1'b0;
      src_r          <= spm_pkg::SRC_NONE;
    end else begin
      wake_ack       <= 1'b0;
      branch_handler <= 1'b0;
      resume_next    <= 1'b0;
      sys_reset_req  <= rst_evt;
      if (rst_evt) begin
        src_r <= spm_pkg::SRC_RESET;
      end else if (wake_evt && nmi_wake) begin
        wake_ack       <= 1'b1;
        branch_handler <= 1'b1;
        src_r          <= pin_nmi_wake ? spm_pkg::SRC_PIN_NMI : spm_pkg::SRC_WDT_NMI;
      end else if (wake_evt) begin
        src_r <= spm_pkg::SRC_MASKABLE;
        if (!low_prio && int_enable) begin
          wake_ack       <= 1'b1;
          branch_handler <= 1'b1;
        end else begin
          resume_next <= 1'b1;
        end
      end
    end
  end

  // Sticky: an unacknowledged waking request is still owed service; set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_hold_r <= 1'b0;
    end else if (wake_evt && !nmi_wake && (low_prio || !int_enable)) begin
      req_hold_r <= 1'b1;
    end else if (rst_evt) begin
      req_hold_r <= 1'b0;
    end else if (wr_stat && wdata_r[spm_pkg::STAT_HOLD_BIT]) begin
      req_hold_r <= 1'b0;
    end
  end

  assign req_hold = req_hold_r;

  // Real-time output trigger
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rto_trigger <= 1'b0;
    end else if (on_sub) begin
      rto_trigger <= rto_sel_timer_match & byte_timer_match_interrupt
                     & byte_timer_external_input;
    end else begin
      rto_trigger <= rto_sel_timer_match ? byte_timer_match_interrupt : rto_other_trigger;
    end
  end

  // Control registers; a reset event restores them like a power-on
  always_ff @(posedge aclk) begin
    if (!aresetn || rst_evt) begin
      pin_nmi_wake_mask_r      <= spm_pkg::WAKE_MASK_RST;
      watchdog_nmi_wake_mask_r <= spm_pkg::WAKE_MASK_RST;
      maskable_wake_mask_r     <= spm_pkg::WAKE_MASK_RST;
      standby_select_bit_r     <= spm_pkg::STANDBY_SEL_RST;
    end else begin
      if (wr_ctrl) begin
        pin_nmi_wake_mask_r      <= wdata_r[spm_pkg::CTRL_PIN_NMI_MASK_BIT];
        watchdog_nmi_wake_mask_r <= wdata_r[spm_pkg::CTRL_WDT_NMI_MASK_BIT];
        maskable_wake_mask_r     <= wdata_r[spm_pkg::CTRL_MASKABLE_MASK_BIT];
      end
      if (wr_mode) begin
        standby_select_bit_r <= wdata_r[spm_pkg::MODE_STANDBY_SEL_BIT];
      end
    end
  end

  // AXI4-Lite write: address and data are captured independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= spm_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_got_r      <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_got_r      <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      spm_pkg::CTRL_OFS: begin
        rd_val[spm_pkg::CTRL_PIN_NMI_MASK_BIT]  = pin_nmi_wake_mask_r;
        rd_val[spm_pkg::CTRL_WDT_NMI_MASK_BIT]  = watchdog_nmi_wake_mask_r;
        rd_val[spm_pkg::CTRL_MASKABLE_MASK_BIT] = maskable_wake_mask_r;
      end
      spm_pkg::MODE_OFS:   rd_val[spm_pkg::MODE_STANDBY_SEL_BIT] = standby_select_bit_r;
      spm_pkg::CLKSEL_OFS: rd_val[spm_pkg::CLKSEL_CPU_SRC_BIT] = on_sub;
      spm_pkg::STAT_OFS: begin
        rd_val[spm_pkg::STAT_STATE_LSB +: 2] = state_r;
        rd_val[spm_pkg::STAT_HOLD_BIT]       = req_hold_r;
        rd_val[spm_pkg::STAT_SRC_LSB +: 3]   = src_r;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= spm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_hit ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  chk_entry_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == spm_pkg::ST_SUBIDLE && $past(state_r) != spm_pkg::ST_SUBIDLE)
    |-> $past(enter_ok))
    else $error("sub-idle entered without valid standby request");

  chk_clock_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == spm_pkg::ST_SUBIDLE |-> osc_en && !cpu_clk_en && !periph_clk_en)
    else $error("clocks wrong in sub-idle");

  chk_ram_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == spm_pkg::ST_SUBIDLE) == (cpu_halt && ram_retain))
    else $error("halt or retention disagrees with state");

  chk_sub_periph: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == spm_pkg::ST_SUBIDLE |-> sub_periph_clk_en)
    else $error("subclock peripherals stopped in sub-idle");

  chk_nmi_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == spm_pkg::ST_SUBIDLE && nmi_wake && !rst_evt)
    |=> state_r == spm_pkg::ST_SUB && wake_ack && branch_handler)
    else $error("NMI wake not acknowledged with branch");

  chk_mask_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == spm_pkg::ST_SUBIDLE && mask_wake && !rst_evt) |=> state_r == spm_pkg::ST_SUB
    ##1 (state_r == spm_pkg::ST_SUB || $past(wr_go || rst_evt)))
    else $error("maskable wake did not return to subclock mode");

  chk_reset_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    rst_evt |=> state_r == spm_pkg::ST_NORMAL && sys_reset_req && !cpu_halt)
    else $error("reset did not restore normal mode");

  chk_low_prio: assert property (@(posedge aclk) disable iff (!aresetn)
    (wake_evt && !nmi_wake && low_prio)
    |=> !wake_ack && resume_next && req_hold)
    else $error("lower priority request was acknowledged");

  chk_di_resume: assert property (@(posedge aclk) disable iff (!aresetn)
    (wake_evt && !nmi_wake && !int_enable) |=> resume_next && !branch_handler)
    else $error("disabled wake did not resume next instruction");

  chk_masked_stay: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == spm_pkg::ST_SUBIDLE && !any_wake && !rst_evt)
    |=> state_r == spm_pkg::ST_SUBIDLE)
    else $error("sub-idle left without unmasked source");

  chk_clk_release: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == spm_pkg::ST_SUB && wr_clk && !wdata_r[spm_pkg::CLKSEL_CPU_SRC_BIT])
    |=> state_r == spm_pkg::ST_NORMAL && cpu_clk_en)
    else $error("clearing clock source did not restore normal");

  chk_rto_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (on_sub && !byte_timer_external_input) |=> !rto_trigger)
    else $error("subclock trigger without external count clock");

endmodule

// [tb/spm_cpu_model.sv]
`timescale 1ns/1ps
module spm_cpu_model (
  input  wire logic aclk,
  output logic      nmi_pin,
  output logic      second_watchdog_interrupt,
  output logic [7:0] external_interrupt_pins,
  output logic [7:0] periph_wake_irq,
  output logic      reset_pin_req,
  output logic      second_watchdog_reset,
  output logic      in_service,
  output logic [2:0] service_prio,
  output logic [2:0] req_prio,
  output logic      int_enable
);
  initial begin
    nmi_pin = 1'b0;
    second_watchdog_interrupt = 1'b0;
    external_interrupt_pins = 8'h00;
    periph_wake_irq = 8'h00;
    reset_pin_req = 1'b0;
    second_watchdog_reset = 1'b0;
    in_service = 1'b0;
    service_prio = 3'h0;
    req_prio = 3'h0;
    int_enable = 1'b0;
  end

  // Requests last n edges only, so a reset level cannot fire a second soft reset
  task automatic raise(input int src, input int n);
    @(posedge aclk);
    case (src)
      0: nmi_pin <= 1'b1;
      1: second_watchdog_interrupt <= 1'b1;
      2: external_interrupt_pins <= 8'h10;
      3: periph_wake_irq <= 8'h01;
      4: reset_pin_req <= 1'b1;
      default: second_watchdog_reset <= 1'b1;
    endcase
    repeat (n) @(posedge aclk);
    nmi_pin <= 1'b0;
    second_watchdog_interrupt <= 1'b0;
    external_interrupt_pins <= 8'h00;
    periph_wake_irq <= 8'h00;
    reset_pin_req <= 1'b0;
    second_watchdog_reset <= 1'b0;
  endtask

  task automatic ctx(input logic svc, input logic [2:0] sp, input logic [2:0] rp,
                     input logic ie);
    @(posedge aclk);
    in_service <= svc;
    service_prio <= sp;
    req_prio <= rp;
    int_enable <= ie;
  endtask

  // Software stays idle after the standby store before anything else
  task automatic nop5();
    repeat (5) @(posedge aclk);
  endtask
endmodule

// [tb/spm_sub_idle_ctrl_tb.sv]
`timescale 1ns/1ps
module spm_sub_idle_ctrl_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, mode_state;
  logic        nmi_pin, second_watchdog_interrupt, reset_pin_req, second_watchdog_reset;
  logic [7:0]  external_interrupt_pins, periph_wake_irq;
  logic        in_service, int_enable;
  logic [2:0]  service_prio, req_prio;
  logic        byte_timer_match_interrupt, rto_sel_timer_match;
  logic        byte_timer_external_input, rto_other_trigger;
  logic        osc_en, cpu_clk_en, periph_clk_en, sub_periph_clk_en, cpu_halt, ram_retain;
  logic        wake_ack, branch_handler, resume_next, req_hold, sys_reset_req, rto_trigger;
  int          fails;
  int          checked;

  spm_sub_idle_ctrl i_dut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .nmi_pin, .second_watchdog_interrupt, .external_interrupt_pins, .periph_wake_irq,
    .req_prio, .in_service, .service_prio, .int_enable, .reset_pin_req,
    .second_watchdog_reset, .byte_timer_match_interrupt, .rto_sel_timer_match,
    .byte_timer_external_input, .rto_other_trigger, .osc_en, .cpu_clk_en,
    .periph_clk_en, .sub_periph_clk_en, .cpu_halt, .ram_retain, .mode_state,
    .wake_ack, .branch_handler, .resume_next, .req_hold, .sys_reset_req, .rto_trigger
  );

  spm_cpu_model i_cpu (
    .aclk, .nmi_pin, .second_watchdog_interrupt, .external_interrupt_pins,
    .periph_wake_irq, .reset_pin_req, .second_watchdog_reset, .in_service,
    .service_prio, .req_prio, .int_enable
  );

  always #5 aclk = ~aclk;

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Ready is sampled at the falling edge, where registered outputs have settled
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic ga, gw, gb;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ga = s_axi_awvalid && s_axi_awready;
      gw = s_axi_wvalid && s_axi_wready;
      gb = s_axi_bvalid;
      if (gb) ck(s_axi_bresp, er);
      @(posedge aclk);
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
      n++;
    end while (!gb && n < 50);
    s_axi_bready <= 1'b0;
    ck(n < 50, 1);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int   n;
    logic ga, gb;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ga = s_axi_arvalid && s_axi_arready;
      gb = s_axi_rvalid;
      if (gb) begin
        ck(s_axi_rdata, ed);
        ck(s_axi_rresp, er);
      end
      @(posedge aclk);
      if (ga) s_axi_arvalid <= 1'b0;
      n++;
    end while (!gb && n < 50);
    s_axi_rready <= 1'b0;
    ck(n < 50, 1);
  endtask

  task automatic idle(input logic [31:0] mask);
    axw(spm_pkg::MODE_OFS, 32'h0, spm_pkg::RESP_OKAY);
    axw(spm_pkg::CTRL_OFS, mask | 32'h8, spm_pkg::RESP_OKAY);
    i_cpu.nop5();
  endtask

  task automatic wake(input int src, input logic [1:0] st, input logic [3:0] pl);
    i_cpu.raise(src, 1);
    #1;
    ck(mode_state, st);
    ck({wake_ack, branch_handler, resume_next, sys_reset_req}, pl);
    @(posedge aclk);
    #1;
    ck({wake_ack, branch_handler, resume_next, sys_reset_req}, 4'h0);
  endtask

  task automatic rto(input logic s, input logic m, input logic e, input logic o,
                     input logic x);
    @(posedge aclk);
    rto_sel_timer_match <= s;
    byte_timer_match_interrupt <= m;
    byte_timer_external_input <= e;
    rto_other_trigger <= o;
    @(posedge aclk);
    #1;
    ck(rto_trigger, x);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    print_verdict();
  end

  initial begin
    fails = 0;
    checked = 0;
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_awprot = 3'h2;
    s_axi_arprot = 3'h2;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {byte_timer_match_interrupt, rto_sel_timer_match} = 2'h0;
    {byte_timer_external_input, rto_other_trigger} = 2'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    ck({osc_en, cpu_clk_en, periph_clk_en}, 3'h7);
    ck({sub_periph_clk_en, cpu_halt, ram_retain}, 3'h4);
    axr(spm_pkg::CTRL_OFS, 32'h0, spm_pkg::RESP_OKAY);
    axr(spm_pkg::MODE_OFS, 32'h1, spm_pkg::RESP_OKAY);
    axr(spm_pkg::CLKSEL_OFS, 32'h0, spm_pkg::RESP_OKAY);
    axr(8'h10, 32'h0, spm_pkg::RESP_SLVERR);
    idle(0);
    ck(mode_state, 2'h0);
    axw(spm_pkg::CLKSEL_OFS, 32'h1, spm_pkg::RESP_OKAY);
    ck(mode_state, 2'h1);
    axw(spm_pkg::MODE_OFS, 32'h1, spm_pkg::RESP_OKAY);
    axw(spm_pkg::CTRL_OFS, 32'h8, spm_pkg::RESP_OKAY);
    ck(mode_state, 2'h1);
    idle(0);
    ck(mode_state, 2'h2);
    ck({osc_en, cpu_clk_en, periph_clk_en}, 3'h4);
    ck({sub_periph_clk_en, cpu_halt, ram_retain}, 3'h7);
    axr(spm_pkg::STAT_OFS, 32'h2, spm_pkg::RESP_OKAY);
    wake(0, 2'h1, 4'hC);
    idle(1);
    i_cpu.raise(0, 4);
    #1;
    ck(mode_state, 2'h2);
    wake(1, 2'h1, 4'hC);
    axr(spm_pkg::STAT_OFS, 32'h11, spm_pkg::RESP_OKAY);
    axr(spm_pkg::CLKSEL_OFS, 32'h1, spm_pkg::RESP_OKAY);
    i_cpu.ctx(1'b1, 3'h2, 3'h3, 1'b1);
    idle(0);
    wake(2, 2'h1, 4'h2);
    ck(req_hold, 1'b1);
    axr(spm_pkg::STAT_OFS, 32'h1D, spm_pkg::RESP_OKAY);
    axw(spm_pkg::STAT_OFS, 32'h4, spm_pkg::RESP_OKAY);
    ck(req_hold, 1'b0);
    i_cpu.ctx(1'b1, 3'h2, 3'h1, 1'b1);
    idle(0);
    wake(3, 2'h1, 4'hC);
    i_cpu.ctx(1'b0, 3'h0, 3'h0, 1'b0);
    idle(0);
    wake(2, 2'h1, 4'h2);
    i_cpu.ctx(1'b0, 3'h0, 3'h5, 1'b1);
    idle(0);
    wake(3, 2'h1, 4'hC);
    i_cpu.ctx(1'b1, 3'h0, 3'h7, 1'b1);
    idle(4);
    i_cpu.raise(2, 3);
    #1;
    ck(mode_state, 2'h2);
    wake(0, 2'h1, 4'hC);
    idle(0);
    wake(4, 2'h0, 4'h1);
    axr(spm_pkg::MODE_OFS, 32'h1, spm_pkg::RESP_OKAY);
    axw(spm_pkg::CLKSEL_OFS, 32'h1, spm_pkg::RESP_OKAY);
    idle(0);
    wake(5, 2'h0, 4'h1);
    axw(spm_pkg::CLKSEL_OFS, 32'h1, spm_pkg::RESP_OKAY);
    ck(mode_state, 2'h1);
    axw(spm_pkg::CLKSEL_OFS, 32'h0, spm_pkg::RESP_OKAY);
    ck(mode_state, 2'h0);
    rto(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    rto(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    axw(spm_pkg::CLKSEL_OFS, 32'h1, spm_pkg::RESP_OKAY);
    rto(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    rto(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    print_verdict();
  end
endmodule
